/* File: hdl/eds_core.sv */
// External data move sequencer with stretchable read and write strobes
`timescale 1ns/1ps

module eds_core
    import eds_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ctl_load,
    input wire eds_ctl_s ctl_wdata,
    output eds_ctl_s clock_control_reg,
    input wire logic req_valid,
    output logic req_ready,
    input wire eds_req_s req,
    output logic done,
    output logic [7:0] rdata,
    output logic ale,
    output logic rd_n,
    output logic wr_n,
    output logic [7:0] addr_hi,
    input wire logic [7:0] ad_in,
    output logic [7:0] ad_out,
    output logic ad_oe_n
);

    // ********************************************************************
    // Clock control register
    // ********************************************************************
    // Loaded by the core; reset lands in divide-by-four
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            clock_control_reg <= eds_ctl_s'(EDS_CTL_RESET);
        end else if (ctl_load) begin
            clock_control_reg <= ctl_wdata;
        end
    end

    // ********************************************************************
    // Length calculation
    // ********************************************************************
    logic [14:0] total_clk;
    logic [14:0] strobe_clk;

    eds_timing u_timing (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ctl(clock_control_reg),
        .total_clk(total_clk),
        .strobe_clk(strobe_clk)
    );

    // ********************************************************************
    // Phase split
    // ********************************************************************
    // Address phase takes half of what the strobe leaves, at least one clock
    // so ALE always pulses; at the fastest settings this adds a clock.
    wire [14:0] spare_clk = (total_clk > strobe_clk) ? 15'(total_clk - strobe_clk) : 15'h0000;
    wire [14:0] half_spare = {1'b0, spare_clk[14:1]};
    wire [14:0] lead_clk = (half_spare == 15'h0000) ? EDS_CNT_ONE : half_spare;
    wire [14:0] tail_clk = (spare_clk > lead_clk) ? 15'(spare_clk - lead_clk) : 15'h0000;

    // ********************************************************************
    // Sequencer
    // ********************************************************************
    eds_state_e state;
    eds_state_e next_state;
    logic [14:0] cnt;
    logic [14:0] next_cnt;
    logic [14:0] strobe_len;
    logic [14:0] tail_len;
    eds_req_s cur;
    logic ale_q;
    logic rd_q;
    logic wr_q;
    logic drive_q;
    logic [7:0] ad_q;

    wire start = req_valid && (state == EDS_IDLE);
    wire cnt_last = (cnt == 15'h0000);
    wire end_strb = (state == EDS_STRB) && cnt_last;
    wire finish = end_strb ? (tail_len == 15'h0000) : ((state == EDS_TAIL) && cnt_last);

    assign req_ready = (state == EDS_IDLE);

    // State and counter selection; phases with zero length are skipped
    always_comb begin
        next_state = state;
        next_cnt = (cnt == 15'h0000) ? 15'h0000 : 15'(cnt - EDS_CNT_ONE);
        case (state)
            EDS_IDLE: begin
                if (req_valid) begin
                    next_state = EDS_LEAD;
                    next_cnt = 15'(lead_clk - EDS_CNT_ONE);
                end
            end
            EDS_LEAD: begin
                if (cnt_last) begin
                    next_state = EDS_STRB;
                    next_cnt = 15'(strobe_len - EDS_CNT_ONE);
                end
            end
            EDS_STRB: begin
                if (cnt_last) begin
                    next_state = (tail_len == 15'h0000) ? EDS_IDLE : EDS_TAIL;
                    next_cnt = (tail_len == 15'h0000) ? 15'h0000 : 15'(tail_len - EDS_CNT_ONE);
                end
            end
            EDS_TAIL: begin
                if (cnt_last) begin
                    next_state = EDS_IDLE;
                end
            end
            default: begin
                next_state = EDS_IDLE;
                next_cnt = 15'h0000;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= EDS_IDLE;
            cnt <= 15'h0000;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // Lengths are frozen at start so a control change mid-move cannot tear it
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            strobe_len <= EDS_CNT_ONE;
            tail_len <= 15'h0000;
            cur <= '0;
        end else if (start) begin
            strobe_len <= strobe_clk;
            tail_len <= tail_clk;
            cur <= req;
        end
    end

    // ********************************************************************
    // Bus pins
    // ********************************************************************
    wire go_strb = (next_state == EDS_STRB);
    wire go_lead = (next_state == EDS_LEAD);
    wire [7:0] next_ad = go_lead ? (start ? req.addr[7:0] : cur.addr[7:0]) : cur.wdata;
    // Address is driven in the lead phase, write data only while writing
    wire next_drive = go_lead || (go_strb && cur.write);

    // Registered pin drivers: strobes idle high, ale low and the bus released after reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ale_q <= 1'b0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            drive_q <= 1'b0;
            ad_q <= 8'h00;
            addr_hi <= 8'h00;
        end else begin
            ale_q <= go_lead;
            rd_q <= go_strb && !cur.write;
            wr_q <= go_strb && cur.write;
            drive_q <= next_drive;
            ad_q <= next_ad;
            if (start) begin
                addr_hi <= req.addr[15:8];
            end
        end
    end

    assign ale = ale_q;
    assign rd_n = !rd_q;
    assign wr_n = !wr_q;
    assign ad_out = ad_q;
    assign ad_oe_n = !drive_q;

    // ********************************************************************
    // Read capture and completion
    // ********************************************************************
    // Sampled in the last strobe clock; the memory must be valid by then
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
            done <= 1'b0;
        end else begin
            if (end_strb && !cur.write) begin
                rdata <= ad_in;
            end
            done <= finish;
        end
    end

endmodule : eds_core

/* File: hdl/eds_pkg.sv */
// Package of types and constants for the external data stretch timing block
package eds_pkg;

    // ********************************************************************
    // Clock control register layout and reset value
    // ********************************************************************
    typedef struct packed {
        logic clock_multiplier_select;
        logic clock_divide_select_hi;
        logic clock_divide_select_lo;
        logic stretch_select_bit2;
        logic stretch_select_bit1;
        logic stretch_select_bit0;
    } eds_ctl_s;

    localparam int EDS_CTL_W = 6;
    // Divide-by-four selected, multiplier select left clear
    localparam logic [5:0] EDS_CTL_RESET = 6'h10;

    // ********************************************************************
    // Request carrier from the core
    // ********************************************************************
    typedef struct packed {
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } eds_req_s;

    // ********************************************************************
    // Timing constants
    // ********************************************************************
    // Oscillator period equals the ref_clk period
    localparam int EDS_OSC_PERIOD_PS = 4000;
    localparam int EDS_CLK_PERIOD_PS = 4000;
    // Quarter oscillator periods per ref_clk cycle
    localparam int EDS_QTR_PER_CLK = 4 * EDS_CLK_PERIOD_PS / EDS_OSC_PERIOD_PS;
    localparam int EDS_QTR_SHIFT = $clog2(EDS_QTR_PER_CLK);

    // Memory-cycle unit in quarter oscillator periods
    localparam logic [12:0] EDS_UNIT_Q_HALF = 13'h0002;
    localparam logic [12:0] EDS_UNIT_Q_ONE = 13'h0004;
    localparam logic [12:0] EDS_UNIT_Q_FOUR = 13'h0010;
    localparam logic [12:0] EDS_UNIT_Q_1024 = 13'h1000;

    // Machine cycles per move, indexed by stretch value
    localparam logic [7:0][3:0] EDS_MOVE_CYCLES =
        {4'hC, 4'hB, 4'hA, 4'h9, 4'h5, 4'h4, 4'h3, 4'h2};

    localparam int EDS_CNT_W = 15;
    localparam logic [14:0] EDS_CNT_ONE = 15'h0001;

    // ********************************************************************
    // Sequencer states
    // ********************************************************************
    typedef enum logic [3:0] {
        EDS_IDLE = 4'b0001,
        EDS_LEAD = 4'b0010,
        EDS_STRB = 4'b0100,
        EDS_TAIL = 4'b1000
    } eds_state_e;

endpackage : eds_pkg

/* File: hdl/eds_timing.sv */
// Converts the clock control setting into move and strobe lengths in clocks
`timescale 1ns/1ps
module eds_timing
    import eds_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire eds_ctl_s ctl,
    output logic [14:0] total_clk,
    output logic [14:0] strobe_clk
);

    // ********************************************************************
    // Unit and length decode
    // ********************************************************************
    wire [2:0] stretch_value = {ctl.stretch_select_bit2, ctl.stretch_select_bit1,
                                ctl.stretch_select_bit0};
    wire [1:0] div_sel = {ctl.clock_divide_select_hi, ctl.clock_divide_select_lo};
    wire [12:0] unit_q;
    wire [3:0] move_cycles;
    wire [16:0] total_q;
    wire [16:0] strobe_q;
    wire [14:0] total_raw;
    wire [14:0] strobe_raw;

    // Code 01 is undefined; it falls back to one period
    assign unit_q = div_sel[1] ? (div_sel[0] ? EDS_UNIT_Q_1024 : EDS_UNIT_Q_FOUR) :
                    ((ctl.clock_multiplier_select && !div_sel[0]) ?
                     EDS_UNIT_Q_HALF : EDS_UNIT_Q_ONE);
    assign move_cycles = EDS_MOVE_CYCLES[stretch_value];
    // Widened before the product so the 1024-period unit cannot wrap
    assign total_q = 17'(move_cycles) * 17'(unit_q);
    // Half a unit at stretch 0, otherwise stretch times the unit
    assign strobe_q = (stretch_value == 3'h0) ? {5'h00, unit_q[12:1]} :
                      17'(stretch_value) * 17'(unit_q);
    // Round up to whole clocks; a half-clock strobe still needs one
    assign total_raw = 15'((total_q + 17'(EDS_QTR_PER_CLK - 1)) >> EDS_QTR_SHIFT);
    assign strobe_raw = 15'((strobe_q + 17'(EDS_QTR_PER_CLK - 1)) >> EDS_QTR_SHIFT);

    // Registered so the sequencer sees a stable, short path
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            total_clk <= EDS_CNT_ONE;
            strobe_clk <= EDS_CNT_ONE;
        end else begin
            total_clk <= (total_raw == 15'h0000) ? EDS_CNT_ONE : total_raw;
            strobe_clk <= (strobe_raw == 15'h0000) ? EDS_CNT_ONE : strobe_raw;
        end
    end

endmodule : eds_timing

/* File: bench/eds_core_asserts.sv */
// Concurrent checks on the external data move sequencer ports
`timescale 1ns/1ps
module eds_core_asserts
    import eds_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ctl_load,
    input wire eds_ctl_s ctl_wdata,
    input wire eds_ctl_s clock_control_reg,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic done,
    input wire logic [7:0] rdata,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic ad_oe_n
);
    // ****
    // Strobe counter and checks
    // ****
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [15:0] low_cnt;
    wire idle_strb = rd_n && wr_n;
    wire [2:0] st = clock_control_reg[2:0];
    // Counts strobe-low clocks so pulse width can be judged at the rising edge
    always_ff @(posedge ref_clk) begin
        if (!rst_n || idle_strb) begin
            low_cnt <= 16'h0000;
        end else begin
            low_cnt <= low_cnt + 16'h0001;
        end
    end
    ale_strobe_a: assert property (ale |-> idle_strb) else $error("ale during strobe");
    one_strobe_a: assert property (rd_n || wr_n) else $error("both strobes low");
    reset_ctl_a: assert property ($rose(rst_n) |-> clock_control_reg == EDS_CTL_RESET)
        else $error("control reset value");
    ctl_load_a: assert property (ctl_load |=> clock_control_reg == $past(ctl_wdata))
        else $error("control not loaded");
    take_ale_a: assert property (req_valid && req_ready |=> ale && !req_ready)
        else $error("move did not start");
    done_once_a: assert property (done |=> !done) else $error("done too long");
    // Divide-by-four only: the multiplier select has no effect there
    strobe_len_a: assert property ($rose(idle_strb) && clock_control_reg[4:3] == 2'b10
        |-> low_cnt == (st == 3'h0 ? 16'h0002 : {11'h000, st, 2'b00}))
        else $error("strobe width");
    rdata_hold_a: assert property (!$stable(rdata) |-> $past(rd_n) == 1'b0 && rd_n)
        else $error("rdata moved off strobe end");
    read_float_a: assert property (!rd_n |-> ad_oe_n) else $error("bus driven in read");
    cover property (done && st == 3'h7);
    cover property ($rose(idle_strb) && st == 3'h0);
    cover property (ctl_load);
endmodule : eds_core_asserts

/* File: bench/eds_mem_model.sv */
// Behavioural byte memory on the multiplexed address/data bus
`timescale 1ns/1ps
module eds_mem_model (
    input wire logic ref_clk,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] addr_hi,
    input wire logic [7:0] ad_out,
    input wire logic ad_oe_n,
    output logic [7:0] ad_in
);
    logic [7:0] mem [0:65535];
    logic [7:0] addr_lo;
    wire [7:0] word = mem[{addr_hi, addr_lo}];
    // Low address caught while ale is high; write byte taken during the strobe
    always @(posedge ref_clk) begin
        if (ale) begin
            addr_lo <= ad_out;
        end
        if (!wr_n && !ad_oe_n) begin
            mem[{addr_hi, addr_lo}] <= ad_out;
        end
    end
    // Outside the read strobe the bus shows the inverse, so a late sample cannot pass by luck
    assign ad_in = rd_n ? ~word : word;
endmodule : eds_mem_model

/* File: bench/external_data_stretch_timing_test.sv */
// Self-checking bench for the external data move sequencer
`timescale 1ns/1ps
module external_data_stretch_timing_test;
    import eds_pkg::*;
    logic ref_clk, rst_n, ctl_load, req_valid, req_ready, done, ale, rd_n, wr_n, ad_oe_n;
    eds_ctl_s ctl_wdata, clock_control_reg;
    eds_req_s req;
    logic [7:0] rdata, addr_hi, ad_in, ad_out;
    logic [5:0] cur;
    logic [31:0] rnd = 32'h0001160E;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    int cyt[8] = '{2, 3, 4, 5, 9, 10, 11, 12};
    logic [5:0] modes[5] = '{6'h10, 6'h00, 6'h20, 6'h30, 6'h08};
    logic [7:0] model [int];

    eds_core i_eds_core (.ref_clk(ref_clk), .rst_n(rst_n), .ctl_load(ctl_load),
        .ctl_wdata(ctl_wdata), .clock_control_reg(clock_control_reg), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .done(done), .rdata(rdata), .ale(ale), .rd_n(rd_n),
        .wr_n(wr_n), .addr_hi(addr_hi), .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n));
    eds_mem_model i_eds_mem_model (.ref_clk(ref_clk), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
        .addr_hi(addr_hi), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .ad_in(ad_in));

    // ****
    // Clock, helpers and tasks
    // ****
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    task automatic complete_run;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run

    task automatic load(input logic [5:0] v);
        @(negedge ref_clk);
        ctl_load = 1'b1;
        ctl_wdata = v;
        cur = v;
        @(negedge ref_clk);
        ctl_load = 1'b0;
        @(negedge ref_clk);
        chk("control", clock_control_reg, v);
    endtask : load

    // One move, timed against lead, strobe and tail lengths from the model
    task automatic move(input logic w, input logic [15:0] ad, input logic [7:0] d);
        int u, st, t, sl, l, tl, n, a, s;
        u = cur[4:3] == 2'b10 ? 16 : cur[4:3] == 2'b11 ? 4096 : cur[5:3] == 3'b100 ? 2 : 4;
        st = cur[2:0];
        t = (cyt[st] * u + 3) / 4;
        sl = st > 0 ? (st * u + 3) / 4 : (u / 2 + 3) / 4;
        l = (t - sl) / 2 > 1 ? (t - sl) / 2 : 1;
        tl = t - sl - l > 0 ? t - sl - l : 0;
        n = 0;
        a = 0;
        s = 0;
        @(negedge ref_clk);
        req_valid = 1'b1;
        req = '{w, ad, d};
        chk("req_ready", req_ready, 1);
        // Pins launch at the take edge, so that edge is the first one counted
        do begin
            @(posedge ref_clk);
            #1;
            n++;
            a += ale;
            s += w ? !wr_n : !rd_n;
            if (n == 1) begin
                @(negedge ref_clk);
                req_valid = 1'b0;
            end
        end while (done !== 1'b1 && n < 99);
        chk("addr_hi", addr_hi, ad[15:8]);
        chk("ale clocks", a, l);
        chk("strobe clocks", s, sl);
        chk("move clocks", n, l + sl + tl + 1);
        if (w) model[ad] = d;
        else chk("rdata", rdata, model[ad]);
    endtask : move

    // Cut a hang short; the run needs about 1500 clocks
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            complete_run;
        end
    end

    // Reset default first, then every stretch code in each clock selection except the 1024-period unit
    initial begin
        rst_n = 1'b0;
        ctl_load = 1'b0;
        ctl_wdata = '0;
        req_valid = 1'b0;
        req = '0;
        repeat (16) @(negedge ref_clk);
        rst_n = 1'b1;
        @(negedge ref_clk);
        chk("reset control", clock_control_reg, EDS_CTL_RESET);
        cur = EDS_CTL_RESET;
        move(1'b1, 16'h5A3C, 8'hC3);
        move(1'b0, 16'h5A3C, 8'hC3);
        foreach (modes[m]) begin
            for (int k = 0; k < 8; k++) begin
                load({modes[m][5:3], k[2:0]});
                rnd = lfsr(rnd);
                move(1'b1, rnd[15:0], rnd[23:16]);
                move(1'b0, rnd[15:0], rnd[23:16]);
            end
        end
        complete_run;
    end
endmodule : external_data_stretch_timing_test

bind eds_core eds_core_asserts i_eds_core_asserts (.ref_clk(ref_clk), .rst_n(rst_n),
    .ctl_load(ctl_load), .ctl_wdata(ctl_wdata), .clock_control_reg(clock_control_reg),
    .req_valid(req_valid), .req_ready(req_ready), .done(done), .rdata(rdata), .ale(ale),
    .rd_n(rd_n), .wr_n(wr_n), .ad_oe_n(ad_oe_n));
